// ---- hdl/timekeep_map.vh ----
`ifndef TIMEKEEP_MAP_VH
`define TIMEKEEP_MAP_VH

`define MEM_DEPTH        2048
`define ADDR_W           11
// Upper address bits that select the clock register window
`define CLK_WIN_HI       8'hFF
// Clock register indices inside the window (byte address 0x7F8 + index)
`define REG_CTRL         3'h0
`define REG_SEC          3'h1
`define REG_MIN          3'h2
`define REG_HOUR         3'h3
`define REG_DAY          3'h4
`define REG_DATE         3'h5
`define REG_MONTH        3'h6
`define REG_YEAR         3'h7
// Control register fields
`define CTRL_READ_BIT    6
`define CTRL_WRITE_BIT   7
// Valid bits of each time field except the year (loaded whole) when loaded into the counters
`define MASK_SEC         8'h7F
`define MASK_MIN         8'h7F
`define MASK_HOUR        8'h3F
`define MASK_DAY         8'h07
`define MASK_DATE        8'h3F
`define MASK_MONTH       8'h1F
// Reset values of the time counters and of the clock registers
`define RST_SEC          8'h00
`define RST_MIN          8'h00
`define RST_HOUR         8'h00
`define RST_DAY          8'h01
`define RST_DATE         8'h01
`define RST_MONTH        8'h01
`define RST_YEAR         8'h00
`define RST_REG          8'h00
// Timing
`define CLK_PERIOD_NS    20
`define ONE_SEC_NS       1000000000
`define SEC_CYCLES       (`ONE_SEC_NS / `CLK_PERIOD_NS)

`endif

// ---- hdl/rtc_counters.v ----
`timescale 1ns/1ps
`include "timekeep_map.vh"

module rtc_counters #(
	parameter SEC_CYCLES = `SEC_CYCLES
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       load,
	input  wire [7:0] ldSec,
	input  wire [7:0] ldMin,
	input  wire [7:0] ldHour,
	input  wire [7:0] ldDay,
	input  wire [7:0] ldDate,
	input  wire [7:0] ldMonth,
	input  wire [7:0] ldYear,
	output reg        secTick,
	output reg  [7:0] sec_ff,
	output reg  [7:0] min_ff,
	output reg  [7:0] hour_ff,
	output reg  [7:0] day_ff,
	output reg  [7:0] date_ff,
	output reg  [7:0] month_ff,
	output reg  [7:0] year_ff
);

	reg  [31:0] div_ff;
	reg  [7:0]  lastDate;
	wire        leap;

	function [7:0] bcdInc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcdInc = {v[7:4] + 4'h1, 4'h0};
			else
				bcdInc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Year divisible by four, evaluated on BCD digits
	assign leap = year_ff[4] ? (year_ff[3:0] == 4'h2 || year_ff[3:0] == 4'h6)
		: (year_ff[3:0] == 4'h0 || year_ff[3:0] == 4'h4 || year_ff[3:0] == 4'h8);

	always @* begin
		case (month_ff)
		8'h02:   lastDate = leap ? 8'h29 : 8'h28;
		8'h04, 8'h06, 8'h09, 8'h11:
			lastDate = 8'h30;
		default: lastDate = 8'h31;
		endcase
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			div_ff  <= 32'h00000000;
			secTick <= 1'b0;
		end else if (div_ff == SEC_CYCLES - 1) begin
			div_ff  <= 32'h00000000;
			secTick <= 1'b1;
		end else begin
			div_ff  <= div_ff + 32'h00000001;
			secTick <= 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			sec_ff   <= `RST_SEC;
			min_ff   <= `RST_MIN;
			hour_ff  <= `RST_HOUR;
			day_ff   <= `RST_DAY;
			date_ff  <= `RST_DATE;
			month_ff <= `RST_MONTH;
			year_ff  <= `RST_YEAR;
		end else if (load) begin
			sec_ff   <= ldSec & `MASK_SEC;
			min_ff   <= ldMin & `MASK_MIN;
			hour_ff  <= ldHour & `MASK_HOUR;
			day_ff   <= ldDay & `MASK_DAY;
			date_ff  <= ldDate & `MASK_DATE;
			month_ff <= ldMonth & `MASK_MONTH;
			year_ff  <= ldYear;
		end else if (secTick) begin
			sec_ff <= (sec_ff == 8'h59) ? 8'h00 : bcdInc(sec_ff);
			if (sec_ff == 8'h59) begin
				min_ff <= (min_ff == 8'h59) ? 8'h00 : bcdInc(min_ff);
				if (min_ff == 8'h59) begin
					hour_ff <= (hour_ff == 8'h23) ? 8'h00 : bcdInc(hour_ff);
					if (hour_ff == 8'h23) begin
						day_ff <= (day_ff == 8'h07) ? 8'h01 : bcdInc(day_ff);
						date_ff <= (date_ff == lastDate) ? 8'h01 : bcdInc(date_ff);
						if (date_ff == lastDate) begin
							month_ff <= (month_ff == 8'h12) ? 8'h01 : bcdInc(month_ff);
							if (month_ff == 8'h12)
								year_ff <= (year_ff == 8'h99) ? 8'h00 : bcdInc(year_ff);
						end
					end
				end
			end
		end
	end

endmodule // rtc_counters

// ---- hdl/timekeeping_sram_port.v ----
`timescale 1ns/1ps
`include "timekeep_map.vh"

module timekeeping_sram_port #(
	parameter SEC_CYCLES = `SEC_CYCLES,
	parameter DEPTH      = `MEM_DEPTH,
	parameter AW         = `ADDR_W
) (
	input  wire          mclk,
	input  wire          rst_n,
	input  wire [AW-1:0] addressLines,
	input  wire          chipSelN,
	input  wire          outEnN,
	input  wire          writeN,
	input  wire [7:0]    dataLinesIn,
	output reg  [7:0]    dataLinesOut,
	output wire          dataLinesOeN,
	input  wire          powerFail
);

	reg  [7:0]    mem [0:DEPTH-1];
	reg  [7:0]    clkReg_ff [0:7];
	reg           wrActive_ff;
	reg  [AW-1:0] wrAddr_ff;
	reg  [7:0]    wrData_ff;
	reg           writeHalt_ff;
	wire          selNow;
	wire          wrNow;
	wire          rdNow;
	wire          wrEnd;
	wire          wrTop;
	wire          rdTop;
	wire          readHalt;
	wire          writeHalt;
	wire          copyNow;
	wire          loadCnt;
	wire          secTick;
	wire [7:0]    cntSec;
	wire [7:0]    cntMin;
	wire [7:0]    cntHour;
	wire [7:0]    cntDay;
	wire [7:0]    cntDate;
	wire [7:0]    cntMonth;
	wire [7:0]    cntYear;
	wire [63:0]   cntBus;

	// Power fail masks every control input
	assign selNow = !chipSelN && !powerFail;
	assign wrNow  = selNow && !writeN;
	assign rdNow  = selNow && writeN;

	assign dataLinesOeN = !(rdNow && !outEnN);

	assign wrTop = (wrAddr_ff[AW-1:3] == `CLK_WIN_HI);
	assign rdTop = (addressLines[AW-1:3] == `CLK_WIN_HI);

	// Write capture: address and data tracked every write cycle, committed at end
	always @(posedge mclk) begin
		if (!rst_n) begin
			wrActive_ff <= 1'b0;
			wrAddr_ff   <= {AW{1'b0}};
			wrData_ff   <= 8'h00;
		end else begin
			wrActive_ff <= wrNow;
			if (wrNow) begin
				wrAddr_ff <= addressLines;
				wrData_ff <= dataLinesIn;
			end
		end
	end

	// Commit on the first deasserted sample; a power fail aborts instead
	assign wrEnd = wrActive_ff && !wrNow && !powerFail;

	// Plain storage, never reset so contents survive power fail
	always @(posedge mclk) begin
		if (wrEnd && !wrTop)
			mem[wrAddr_ff] <= wrData_ff;
	end

	// Read data registered each cycle, so it follows the address
	always @(posedge mclk) begin
		if (!rst_n)
			dataLinesOut <= 8'h00;
		else if (rdTop)
			dataLinesOut <= clkReg_ff[addressLines[2:0]];
		else
			dataLinesOut <= mem[addressLines];
	end

	assign readHalt  = clkReg_ff[`REG_CTRL][`CTRL_READ_BIT];
	assign writeHalt = clkReg_ff[`REG_CTRL][`CTRL_WRITE_BIT];
	// Copy is one cycle wide, so a halt never splits it
	// Skipped in the load cycle: the counters still hold the old time then
	assign copyNow   = secTick && !readHalt && !writeHalt && !loadCnt;

	always @(posedge mclk) begin
		if (!rst_n)
			writeHalt_ff <= 1'b0;
		else
			writeHalt_ff <= writeHalt;
	end

	assign loadCnt = writeHalt_ff && !writeHalt;

	assign cntBus = {cntYear, cntMonth, cntDate, cntDay, cntHour, cntMin, cntSec, 8'h00};

	// Clock register file: a separate port from the counters, beside the main array
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gReg
			always @(posedge mclk) begin
				if (!rst_n)
					clkReg_ff[g] <= `RST_REG;
				else if (wrEnd && wrTop && wrAddr_ff[2:0] == g)
					clkReg_ff[g] <= wrData_ff;
				else if (copyNow && g != `REG_CTRL)
					clkReg_ff[g] <= cntBus[g*8 +: 8];
			end
		end
	endgenerate

	rtc_counters #(
		.SEC_CYCLES (SEC_CYCLES)
	) uCounters (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.load     (loadCnt),
		.ldSec    (clkReg_ff[`REG_SEC]),
		.ldMin    (clkReg_ff[`REG_MIN]),
		.ldHour   (clkReg_ff[`REG_HOUR]),
		.ldDay    (clkReg_ff[`REG_DAY]),
		.ldDate   (clkReg_ff[`REG_DATE]),
		.ldMonth  (clkReg_ff[`REG_MONTH]),
		.ldYear   (clkReg_ff[`REG_YEAR]),
		.secTick  (secTick),
		.sec_ff   (cntSec),
		.min_ff   (cntMin),
		.hour_ff  (cntHour),
		.day_ff   (cntDay),
		.date_ff  (cntDate),
		.month_ff (cntMonth),
		.year_ff  (cntYear)
	);

endmodule // timekeeping_sram_port

// ---- sim/timekeeping_sram_port_chk.sv ----
`timescale 1ns/1ps
module timekeeping_sram_port_chk (
	input logic        mclk,
	input logic        rst_n,
	input logic [10:0] addressLines,
	input logic        chipSelN,
	input logic        outEnN,
	input logic        writeN,
	input logic [7:0]  dataLinesIn,
	input logic [7:0]  dataLinesOut,
	input logic        dataLinesOeN,
	input logic        powerFail
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire rdNow = !chipSelN && writeN && !powerFail;
	wire wrAct = !chipSelN && !writeN && !powerFail;
	// Clock registers left out: a copy may change them between reads
	wire plain = addressLines < 11'h7F8;
	drive_read_a: assert property (rdNow && !outEnN |-> !dataLinesOeN)
		else $error("read not driven");
	idle_float_a: assert property (chipSelN || outEnN |-> dataLinesOeN)
		else $error("driven while off");
	pf_float_a: assert property (powerFail |-> dataLinesOeN)
		else $error("driven in power fail");
	write_float_a: assert property (!writeN |-> dataLinesOeN)
		else $error("driven in write");
	write_back_a: assert property (wrAct ##1 (!wrAct && !powerFail) ##1 (rdNow && plain
		&& addressLines == $past(addressLines, 2)) |=> dataLinesOut == $past(dataLinesIn, 3))
		else $error("stored byte lost");
	read_hold_a: assert property ((rdNow && plain && !$past(wrAct)) ##1
		(rdNow && $stable(addressLines)) |=> $stable(dataLinesOut)) else $error("byte changed");
	ctrl_hold_a: assert property ((rdNow && addressLines == 11'h7F8 && !$past(wrAct)) ##1
		(rdNow && $stable(addressLines)) |=> $stable(dataLinesOut)) else $error("ctrl changed");
	sec_bcd_a: assert property (rdNow && addressLines == 11'h7F9 |=> dataLinesOut < 8'h60)
		else $error("seconds out of range");
	cover property (wrAct ##1 !wrAct ##1 rdNow);
	cover property (powerFail && !chipSelN);
	cover property (rdNow && addressLines == 11'h7FD);
	cover property (rdNow && outEnN);
endmodule // timekeeping_sram_port_chk

bind timekeeping_sram_port timekeeping_sram_port_chk i_timekeeping_sram_port_chk (.mclk(mclk),
	.rst_n(rst_n), .addressLines(addressLines), .chipSelN(chipSelN), .outEnN(outEnN),
	.writeN(writeN), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
	.dataLinesOeN(dataLinesOeN), .powerFail(powerFail));

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model (
	input  logic        mclk,
	input  logic [7:0]  dataLinesOut,
	input  logic        dataLinesOeN,
	output logic [10:0] addressLines,
	output logic        chipSelN,
	output logic        outEnN,
	output logic        writeN,
	output logic [7:0]  dataLinesIn
);
	// Undriven lines read inverted so a floating bus never matches
	wire [7:0] bus = dataLinesOeN ? ~dataLinesOut : dataLinesOut;
	initial begin
		addressLines = 11'h000;
		{chipSelN, outEnN, writeN} = 3'h7;
		dataLinesIn = 8'h00;
	end
	task automatic idle();
		{chipSelN, outEnN, writeN} = 3'h7;
		dataLinesIn = ~dataLinesIn;
	endtask
	// Output enable level is free during a write
	task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic oeN);
		@(posedge mclk) #1;
		addressLines = a;
		dataLinesIn = d;
		{chipSelN, outEnN, writeN} = {1'b0, oeN, 1'b0};
		@(posedge mclk) #1;
		idle();
	endtask
	// Select stays low after a read so the next read ripples through
	task automatic rd(input logic [10:0] a, input logic oeN, output logic [7:0] d,
		output logic drove);
		@(posedge mclk) #1;
		addressLines = a;
		{chipSelN, outEnN, writeN} = {1'b0, oeN, 1'b1};
		@(posedge mclk) #1;
		d = bus;
		drove = !dataLinesOeN;
	endtask
endmodule // host_bus_model

// ---- sim/timekeeping_sram_port_test.sv ----
`timescale 1ns/1ps
module timekeeping_sram_port_test;
	logic        mclk;
	logic        rst_n;
	logic        powerFail;
	wire  [10:0] addressLines;
	wire         chipSelN;
	wire         outEnN;
	wire         writeN;
	wire  [7:0]  dataLinesIn;
	wire  [7:0]  dataLinesOut;
	wire         dataLinesOeN;
	int          err_total = 0;
	int          check_count = 0;
	logic [7:0]  rv;
	logic [7:0]  secSnap;
	logic        drove;
	timekeeping_sram_port #(.SEC_CYCLES(20)) i_timekeeping_sram_port (.mclk(mclk),
		.rst_n(rst_n), .addressLines(addressLines), .chipSelN(chipSelN), .outEnN(outEnN),
		.writeN(writeN), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
		.dataLinesOeN(dataLinesOeN), .powerFail(powerFail));
	host_bus_model i_host_bus_model (.mclk(mclk), .dataLinesOut(dataLinesOut),
		.dataLinesOeN(dataLinesOeN), .addressLines(addressLines), .chipSelN(chipSelN),
		.outEnN(outEnN), .writeN(writeN), .dataLinesIn(dataLinesIn));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("%0d checks, %0d mismatches", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		i_host_bus_model.wr(a, d, 1'b0);
	endtask
	task automatic rd(input logic [10:0] a);
		i_host_bus_model.rd(a, 1'b0, rv, drove);
	endtask
	task automatic t_ram();
		wr(11'h000, 8'hA5);
		wr(11'h7F7, 8'h3C);
		rd(11'h7F7);
		check(rv, 8'h3C);
		rd(11'h000);
		check(rv, 8'hA5);
		check({7'h00, drove}, 8'h01);
		i_host_bus_model.wr(11'h020, 8'h96, 1'b1);
		rd(11'h020);
		check(rv, 8'h96);
		i_host_bus_model.rd(11'h020, 1'b1, rv, drove);
		check({7'h00, drove}, 8'h00);
		$display("plain memory test done");
	endtask
	task automatic t_pf();
		wr(11'h010, 8'h5A);
		@(posedge mclk) #1 powerFail = 1'b1;
		wr(11'h010, 8'hC3);
		rd(11'h010);
		check({7'h00, drove}, 8'h00);
		i_host_bus_model.idle();
		@(posedge mclk) #1 powerFail = 1'b0;
		rd(11'h010);
		rd(11'h010);
		check(rv, 8'h5A);
		$display("power fail test done");
	endtask
	task automatic t_clock(input logic [7:0] yr, input logic [7:0] expDate,
		input logic [7:0] expMon);
		logic [7:0] setTime [7];
		int n;
		setTime = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, yr};
		wr(11'h7F8, 8'h80);
		for (n = 0; n < 7; n++)
			wr(11'h7F9 + 11'(n), setTime[n]);
		wr(11'h7F8, 8'h00);
		rd(11'h7FF);
		check(rv, yr);
		rv = 8'h00;
		for (n = 0; n < 200 && rv !== expDate; n++)
			rd(11'h7FD);
		check(rv, expDate);
		if (rv !== expDate)
			close_out();
		rd(11'h7FE);
		check(rv, expMon);
		rd(11'h7FB);
		check(rv, 8'h00);
		wr(11'h7F8, 8'h40);
		rd(11'h7F9);
		secSnap = rv;
		repeat (60) @(posedge mclk);
		rd(11'h7F9);
		check(rv, secSnap);
		rd(11'h7F8);
		rd(11'h7F8);
		check(rv, 8'h40);
		wr(11'h7F8, 8'h00);
		repeat (60) @(posedge mclk);
		rd(11'h7F9);
		check({7'h00, rv != secSnap}, 8'h01);
		$display("clock test done");
	endtask
	initial begin
		rst_n = 1'b0;
		powerFail = 1'b0;
		repeat (16) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_ram();
		t_pf();
		t_clock(8'h24, 8'h29, 8'h02);
		t_clock(8'h23, 8'h01, 8'h03);
		close_out();
	end
endmodule // timekeeping_sram_port_test
